/* hdl/apdc_pkg.sv */
// constants for one axis of the pulse-train drive controller
package apdc_pkg;
    localparam int POS_W = 32;
    localparam int SPD_W = 16;
    localparam logic signed [15:0] ACC_OFS_RST = 16'sh0008;
    localparam logic [2:0] FLT_SEL_RST = 3'h0;
    localparam logic [5:0] STOP_MODE_RST = 6'h00;
    localparam logic [2:0] DRV_MODE_RST = 3'h0;
    // drive mode register three bit positions
    localparam int DM3_MANUAL_DECEL = 0;
    localparam int DM3_ACCEL_EN = 1;
    localparam int DM3_CONT_SPEED_CHG = 2;
    // filter: base count of the smallest time constant, doubled per select step
    localparam int FLT_BASE_CNT = 2;
    localparam int FLT_CNT_W = 10;
    // pulse period divider base (cycles per speed unit step)
    localparam int SPEED_DIV_W = 24;
    localparam logic [23:0] SPEED_DIV_NUM = 24'h00FFFF;
    // speed step applied per accel tick
    localparam logic [15:0] SPEED_STEP = 16'h0001;
    typedef enum logic [2:0] {APDC_IDLE, APDC_ACCEL, APDC_CONST, APDC_DECEL, APDC_CREEP}
        apdc_state_e;
endpackage

/* hdl/apdc_axis.sv */
// single-axis pulse drive controller with compare, filters and stop inputs
`timescale 1ns/100ps
module apdc_axis #(
    parameter int POS_W = apdc_pkg::POS_W,
    parameter int SPD_W = apdc_pkg::SPD_W,
    parameter int N_IN = 10
) (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic i_cmd_plus_fixed,
    input wire logic i_cmd_minus_fixed,
    input wire logic i_cmd_plus_cont,
    input wire logic i_cmd_minus_cont,
    input wire logic i_cmd_decel_stop,
    input wire logic i_cmd_sudden_stop,
    input wire logic i_cmd_set_decel_point,
    input wire logic i_cmd_set_offset,
    input wire logic i_cmd_set_pulses,
    input wire logic [POS_W-1:0] i_pulse_count,
    input wire logic [POS_W-1:0] i_decel_point,
    input wire logic signed [15:0] i_accel_offset,
    input wire logic [SPD_W-1:0] i_initial_speed,
    input wire logic [SPD_W-1:0] i_drive_speed,
    input wire logic [2:0] i_drive_mode_register_three,
    input wire logic [5:0] i_stop_input_mode_register,
    input wire logic [POS_W-1:0] i_cmp_logical,
    input wire logic [POS_W-1:0] i_cmp_real,
    input wire logic i_soft_limit_en,
    input wire logic [N_IN-1:0] i_filter_en,
    input wire logic [2:0] i_filter_sel,
    input wire logic [3:0] i_irq_en,
    input wire logic i_irq_clear,
    input wire logic i_halt_input_zero,
    input wire logic i_halt_input_one,
    input wire logic i_halt_input_two,
    input wire logic i_ext_plus_fixed,
    input wire logic i_ext_minus_fixed,
    input wire logic i_ext_cont_mode,
    input wire logic i_pulser_a,
    input wire logic i_pulser_b,
    input wire logic i_enc_a,
    input wire logic i_enc_b,
    output logic O_PULSE,
    output logic O_DIR,
    output logic O_DRIVING,
    output logic O_ACCEL,
    output logic O_DECEL,
    output logic [POS_W-1:0] O_LOGICAL_POS,
    output logic [POS_W-1:0] O_REAL_POS,
    output logic [SPD_W-1:0] O_SPEED,
    output logic O_CMP_LOG_GE,
    output logic O_CMP_REAL_GE,
    output logic O_LIMIT_HIT,
    output logic [3:0] O_IRQ_FLAGS,
    output logic O_INT
);
    localparam int FW = apdc_pkg::FLT_CNT_W;

    // filtered inputs: halt0..2, ext+,ext-,extcont, pulser a/b, enc a/b
    logic [N_IN-1:0] raw_in;
    logic [N_IN-1:0] flt_r;
    logic [FW-1:0] flt_cnt_r [N_IN];
    logic [FW-1:0] flt_lim;
    assign raw_in = {i_enc_b, i_enc_a, i_pulser_b, i_pulser_a, i_ext_cont_mode,
                     i_ext_minus_fixed, i_ext_plus_fixed, i_halt_input_two,
                     i_halt_input_one, i_halt_input_zero};
    assign flt_lim = FW'(apdc_pkg::FLT_BASE_CNT) << i_filter_sel;

    // integrating filter: counter walks toward the input, output flips at the ends
    genvar g;
    generate
        for (g = 0; g < N_IN; g++) begin : g_flt
            always_ff @(posedge I_CLK or posedge I_RESET) begin
                if (I_RESET) begin
                    flt_cnt_r[g] <= '0;
                    flt_r[g] <= 1'b0;
                end else if (!i_filter_en[g]) begin
                    flt_r[g] <= raw_in[g];
                    flt_cnt_r[g] <= raw_in[g] ? flt_lim : '0;
                end else if (raw_in[g] && flt_cnt_r[g] < flt_lim) begin
                    flt_cnt_r[g] <= flt_cnt_r[g] + 1'b1;
                end else if (!raw_in[g] && flt_cnt_r[g] != '0) begin
                    flt_cnt_r[g] <= flt_cnt_r[g] - 1'b1;
                end else begin
                    flt_r[g] <= raw_in[g];
                end
            end
        end
    endgenerate

    logic [N_IN-1:0] flt_d_r;
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) flt_d_r <= '0;
        else flt_d_r <= flt_r;
    end

    // halt inputs: even mode bits enable, odd mode bits select active-high
    logic [2:0] halt_act;
    generate
        for (g = 0; g < 3; g++) begin : g_halt
            assign halt_act[g] = i_stop_input_mode_register[2*g] &&
                (flt_r[g] == i_stop_input_mode_register[2*g+1]);
        end
    endgenerate
    wire halt_any = |halt_act;

    apdc_pkg::apdc_state_e state_r, state_nxt;
    logic cont_r, dir_r;
    logic [POS_W-1:0] target_r, out_cnt_r, accel_pulses_r;
    logic [SPD_W-1:0] speed_r;
    logic [23:0] per_cnt_r;
    logic signed [15:0] offset_r;
    logic [POS_W-1:0] decel_pt_r;
    logic ofs_set_r;
    logic pulse_r;
    logic [POS_W-1:0] lpos_r, rpos_r;

    wire manual_decel = i_drive_mode_register_three[apdc_pkg::DM3_MANUAL_DECEL];
    wire accel_en = i_drive_mode_register_three[apdc_pkg::DM3_ACCEL_EN];
    wire ext_fixed_p = flt_r[3] & ~flt_d_r[3];
    wire ext_fixed_m = flt_r[4] & ~flt_d_r[4];
    wire start_p = i_cmd_plus_fixed | i_cmd_plus_cont | (ext_fixed_p & ~flt_r[5]);
    wire start_m = i_cmd_minus_fixed | i_cmd_minus_cont | (ext_fixed_m & ~flt_r[5]);
    wire start_cont = i_cmd_plus_cont | i_cmd_minus_cont;
    wire idle = (state_r == apdc_pkg::APDC_IDLE);
    wire ext_cont_run = flt_r[5] & (flt_r[3] | flt_r[4]);
    wire ext_run_fell = flt_d_r[5] & (flt_d_r[3] | flt_d_r[4]) & ~ext_cont_run;

    // pulse tick from the current speed
    wire tick = (state_r != apdc_pkg::APDC_IDLE) && (per_cnt_r == 24'h000000);
    wire [POS_W-1:0] remaining = (target_r > out_cnt_r) ? target_r - out_cnt_r : '0;
    wire signed [POS_W:0] decel_thr_s = $signed({1'b0, accel_pulses_r}) +
        POS_W'(offset_r);
    wire [POS_W-1:0] decel_thr = decel_thr_s[POS_W] ? '0 : decel_thr_s[POS_W-1:0];
    wire auto_decel_hit = manual_decel ? (remaining <= decel_pt_r)
                                       : (!decel_thr_s[POS_W] && remaining <= decel_thr);
    wire fixed_done = !cont_r && (out_cnt_r >= target_r);
    wire lim_hit = i_soft_limit_en && ((dir_r == 1'b0 && O_CMP_LOG_GE) ||
        (dir_r == 1'b1 && !O_CMP_LOG_GE));
    wire sudden = i_cmd_sudden_stop || lim_hit ||
        (halt_any && cont_r && state_r == apdc_pkg::APDC_CONST && !accel_en);
    wire soft_stop = i_cmd_decel_stop || (halt_any && (cont_r ? accel_en : 1'b1));
    logic [SPD_W-1:0] speed_nxt;
    logic ramp_up_done;
    assign ramp_up_done = speed_r >= i_drive_speed;

    always_comb begin
        state_nxt = state_r;
        speed_nxt = speed_r;
        unique case (state_r)
            apdc_pkg::APDC_IDLE: begin
                speed_nxt = i_initial_speed;
                if (start_p || start_m || ext_cont_run) begin
                    // profile picked from mode and speeds
                    state_nxt = (accel_en && i_drive_speed > i_initial_speed) ?
                        apdc_pkg::APDC_ACCEL : apdc_pkg::APDC_CONST;
                end
            end
            apdc_pkg::APDC_ACCEL: begin
                if (tick) speed_nxt = speed_r + apdc_pkg::SPEED_STEP;
                if (ramp_up_done) state_nxt = apdc_pkg::APDC_CONST;
                if (!cont_r && auto_decel_hit) state_nxt = apdc_pkg::APDC_DECEL;
            end
            apdc_pkg::APDC_CONST: begin
                speed_nxt = i_drive_speed;
                if (!cont_r && auto_decel_hit && accel_en) state_nxt = apdc_pkg::APDC_DECEL;
            end
            apdc_pkg::APDC_DECEL: begin
                if (tick && speed_r > i_initial_speed) speed_nxt = speed_r - apdc_pkg::SPEED_STEP;
                if (speed_r <= i_initial_speed) begin
                    state_nxt = cont_r ? apdc_pkg::APDC_IDLE : apdc_pkg::APDC_CREEP;
                end
            end
            apdc_pkg::APDC_CREEP: speed_nxt = i_initial_speed;
        endcase
        if (!idle && soft_stop && state_r != apdc_pkg::APDC_CREEP &&
            state_nxt != apdc_pkg::APDC_IDLE) begin
            state_nxt = accel_en ? apdc_pkg::APDC_DECEL : apdc_pkg::APDC_IDLE;
        end
        // releasing the external run inputs ends an externally held drive in any phase
        if (!idle && cont_r && ext_run_fell) state_nxt = apdc_pkg::APDC_IDLE;
        if (!idle && (sudden || fixed_done)) state_nxt = apdc_pkg::APDC_IDLE;
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_r <= apdc_pkg::APDC_IDLE;
            speed_r <= '0;
        end else begin
            state_r <= state_nxt;
            speed_r <= speed_nxt;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            cont_r <= 1'b0;
            dir_r <= 1'b0;
            target_r <= '0;
        end else if (idle && (start_p || start_m || ext_cont_run)) begin
            cont_r <= start_cont || ext_cont_run;
            dir_r <= start_m || (ext_cont_run && flt_r[4]);
            target_r <= i_pulse_count;
        end else if (i_cmd_set_pulses) begin
            target_r <= i_pulse_count;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) offset_r <= apdc_pkg::ACC_OFS_RST;
        else if (i_cmd_set_offset) offset_r <= i_accel_offset;
    end

    // decel point is latched by its strobe, so later edits of the input do not move it
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            decel_pt_r <= '0;
            ofs_set_r <= 1'b0;
        end else begin
            if (i_cmd_set_decel_point) decel_pt_r <= i_decel_point;
            if (i_cmd_set_offset) ofs_set_r <= 1'b1;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            per_cnt_r <= '0;
            pulse_r <= 1'b0;
            out_cnt_r <= '0;
            accel_pulses_r <= '0;
        end else if (idle) begin
            per_cnt_r <= '0;
            pulse_r <= 1'b0;
            if (start_p || start_m || ext_cont_run) begin
                out_cnt_r <= '0;
                accel_pulses_r <= '0;
            end
        end else if (tick) begin
            per_cnt_r <= apdc_pkg::SPEED_DIV_NUM / 24'(speed_r == '0 ? 1 : speed_r);
            pulse_r <= 1'b1;
            out_cnt_r <= out_cnt_r + 1'b1;
            if (state_r == apdc_pkg::APDC_ACCEL) accel_pulses_r <= accel_pulses_r + 1'b1;
        end else begin
            per_cnt_r <= per_cnt_r - 1'b1;
            pulse_r <= 1'b0;
        end
    end

    // pulser and encoder quadrature decoding
    function automatic logic [1:0] quad(input logic a, input logic b, input logic pa,
                                         input logic pb);
        logic up;
        logic dn;
        up = (a ^ pa) ? (a ^ b) : ((b ^ pb) ? ~(a ^ b) : 1'b0);
        dn = (a ^ pa) ? ~(a ^ b) : ((b ^ pb) ? (a ^ b) : 1'b0);
        quad = {dn, up};
    endfunction
    wire [1:0] enc_step = quad(flt_r[8], flt_r[9], flt_d_r[8], flt_d_r[9]);
    wire [1:0] pls_step = quad(flt_r[6], flt_r[7], flt_d_r[6], flt_d_r[7]);

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            lpos_r <= '0;
            rpos_r <= '0;
        end else begin
            if (tick) lpos_r <= dir_r ? lpos_r - 1'b1 : lpos_r + 1'b1;
            else if (idle && pls_step[0]) lpos_r <= lpos_r + 1'b1;
            else if (idle && pls_step[1]) lpos_r <= lpos_r - 1'b1;
            if (enc_step[0]) rpos_r <= rpos_r + 1'b1;
            else if (enc_step[1]) rpos_r <= rpos_r - 1'b1;
        end
    end

    wire cmp_l = $signed(lpos_r) >= $signed(i_cmp_logical);
    wire cmp_r = $signed(rpos_r) >= $signed(i_cmp_real);
    logic cmp_l_d_r, cmp_r_d_r, const_d_r, drv_d_r;
    logic [3:0] irq_r;
    wire is_const = state_r == apdc_pkg::APDC_CONST;
    wire [3:0] ev = {cmp_r ^ cmp_r_d_r, cmp_l ^ cmp_l_d_r, drv_d_r & idle,
                     (is_const ^ const_d_r) & accel_en};

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            cmp_l_d_r <= 1'b0;
            cmp_r_d_r <= 1'b0;
            const_d_r <= 1'b0;
            drv_d_r <= 1'b0;
            irq_r <= '0;
        end else begin
            cmp_l_d_r <= cmp_l;
            cmp_r_d_r <= cmp_r;
            const_d_r <= is_const;
            drv_d_r <= !idle;
            // set wins over clear
            irq_r <= ((i_irq_clear ? 4'h0 : irq_r) | (ev & i_irq_en));
        end
    end

    assign O_PULSE = pulse_r;
    assign O_DIR = dir_r;
    assign O_DRIVING = drv_d_r;
    assign O_ACCEL = (state_r == apdc_pkg::APDC_ACCEL);
    assign O_DECEL = (state_r == apdc_pkg::APDC_DECEL);
    assign O_LOGICAL_POS = lpos_r;
    assign O_REAL_POS = rpos_r;
    assign O_SPEED = speed_r;
    assign O_CMP_LOG_GE = cmp_l_d_r;
    assign O_CMP_REAL_GE = cmp_r_d_r;
    assign O_LIMIT_HIT = lim_hit;
    assign O_IRQ_FLAGS = irq_r;
    assign O_INT = |irq_r;

    a_sudden_quiet: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (!idle && i_cmd_sudden_stop) |-> ##2 !pulse_r)
        else $error("pulse after sudden stop");
    a_sudden_ends: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (!idle && i_cmd_sudden_stop) |=> idle) else $error("sudden stop");
    a_offset_rst: assert property (@(posedge I_CLK) disable iff (I_RESET)
        !ofs_set_r |-> offset_r == apdc_pkg::ACC_OFS_RST) else $error("offset");
    a_int_follows: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (|(ev & i_irq_en)) |=> O_INT) else $error("interrupt not raised");
    a_fixed_end: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (!idle && !cont_r && out_cnt_r >= target_r) |=> idle)
        else $error("fixed drive overran");
    a_cmp_flag: assert property (@(posedge I_CLK) disable iff (I_RESET)
        !$past(I_RESET) |-> O_CMP_LOG_GE == $past(cmp_l)) else $error("compare flag late");
    a_lpos_step: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (tick && !dir_r) |=> lpos_r == $past(lpos_r) + 1'b1)
        else $error("logical count wrong");
    a_drive_end_irq: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (drv_d_r && idle && i_irq_en[1]) |=> irq_r[1]) else $error("end irq lost");
    a_halt_stop: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (state_r == apdc_pkg::APDC_CONST && cont_r && !accel_en && halt_any) |=> idle)
        else $error("halt did not stop");
endmodule

/* verification/apdc_enc_model.sv */
// encoder emulator that turns the axis output pulses into quadrature feedback
`timescale 1ns/100ps
module apdc_enc_model (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic i_pulse,
    input wire logic i_dir,
    output logic o_enc_a,
    output logic o_enc_b
);
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;
    // one quadrature step per pulse, a leads b on plus travel
    assign phase_nxt = i_dir ? phase_r - 2'h1 : phase_r + 2'h1;
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET)
            phase_r <= 2'h0;
        else if (i_pulse)
            phase_r <= phase_nxt;
    end
    assign o_enc_a = phase_r[0] ^ phase_r[1];
    assign o_enc_b = phase_r[1];
endmodule

/* verification/test_apdc_axis.sv */
// self-checking bench for the single-axis pulse drive controller
`timescale 1ns/100ps
module test_apdc_axis;
    logic I_CLK = 1'b0;
    logic I_RESET = 1'b1;
    logic [8:0] cmd = 9'h000;
    logic [31:0] cnt = 32'h0;
    logic [31:0] dpt = 32'h0;
    logic [31:0] cl = 32'h0;
    logic [31:0] cr = 32'h0;
    logic signed [15:0] ofs = 16'sh0008;
    logic [15:0] sv = 16'h1000;
    logic [15:0] dv = 16'h1000;
    logic [2:0] dm = 3'h0;
    logic [5:0] sm = 6'h00;
    logic [9:0] fen = 10'h000;
    logic [2:0] fsel = 3'h0;
    logic [3:0] ien = 4'h0;
    logic [2:0] halt = 3'h0;
    logic [2:0] ext = 3'h0;
    logic lim = 1'b0;
    logic iclr = 1'b0;
    logic enc_a, enc_b, pul, dir, drv, acc, dec, cge, rge, lhit, intr;
    logic [31:0] lpos, rpos;
    logic [15:0] spd;
    logic [3:0] flags;
    int errors = 0;
    int checks_done = 0;
    int pcount = 0;
    bit sawdec = 1'b0;
    bit sawacc = 1'b0;
    int dec_at = 0;

    apdc_axis uut (.I_CLK(I_CLK), .I_RESET(I_RESET),
        .i_cmd_plus_fixed(cmd[0]), .i_cmd_minus_fixed(cmd[1]), .i_cmd_plus_cont(cmd[2]),
        .i_cmd_minus_cont(cmd[3]), .i_cmd_decel_stop(cmd[4]), .i_cmd_sudden_stop(cmd[5]),
        .i_cmd_set_decel_point(cmd[6]), .i_cmd_set_offset(cmd[7]), .i_cmd_set_pulses(cmd[8]),
        .i_pulse_count(cnt), .i_decel_point(dpt), .i_accel_offset(ofs),
        .i_initial_speed(sv), .i_drive_speed(dv), .i_drive_mode_register_three(dm),
        .i_stop_input_mode_register(sm), .i_cmp_logical(cl), .i_cmp_real(cr),
        .i_soft_limit_en(lim), .i_filter_en(fen), .i_filter_sel(fsel), .i_irq_en(ien),
        .i_irq_clear(iclr), .i_halt_input_zero(halt[0]), .i_halt_input_one(halt[1]),
        .i_halt_input_two(halt[2]), .i_ext_plus_fixed(ext[0]), .i_ext_minus_fixed(ext[1]),
        .i_ext_cont_mode(ext[2]), .i_pulser_a(1'b0), .i_pulser_b(1'b0),
        .i_enc_a(enc_a), .i_enc_b(enc_b), .O_PULSE(pul), .O_DIR(dir), .O_DRIVING(drv),
        .O_ACCEL(acc), .O_DECEL(dec), .O_LOGICAL_POS(lpos), .O_REAL_POS(rpos),
        .O_SPEED(spd), .O_CMP_LOG_GE(cge), .O_CMP_REAL_GE(rge), .O_LIMIT_HIT(lhit),
        .O_IRQ_FLAGS(flags), .O_INT(intr));
    apdc_enc_model enc (.I_CLK(I_CLK), .I_RESET(I_RESET), .i_pulse(pul), .i_dir(dir),
        .o_enc_a(enc_a), .o_enc_b(enc_b));

    initial begin
        forever #50 I_CLK = ~I_CLK;
    end
    always @(posedge I_CLK) begin
        if (pul === 1'b1)
            pcount++;
        if (dec === 1'b1 && !sawdec)
            dec_at = pcount;
        if (dec === 1'b1)
            sawdec = 1'b1;
        if (acc === 1'b1)
            sawacc = 1'b1;
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge I_CLK);
    endtask
    task automatic go(input int k);
        @(posedge I_CLK);
        cmd <= 9'h001 << k;
        @(posedge I_CLK);
        cmd <= 9'h000;
    endtask
    task automatic load(input logic [31:0] v);
        @(posedge I_CLK);
        cnt <= v;
        cmd <= 9'h100;
        @(posedge I_CLK);
        cmd <= 9'h000;
    endtask
    // busy goes high a cycle late, so give it time before polling for the end
    task automatic idle();
        int i;
        cyc(3);
        for (i = 0; i < 4000 && drv !== 1'b0; i++)
            @(negedge I_CLK);
        cyc(4);
        check("drive end", drv, 32'h0);
    endtask
    task automatic upto(input int n);
        int i;
        for (i = 0; i < 4000 && pcount < n; i++)
            @(negedge I_CLK);
    endtask

    task automatic t_fixed();
        @(posedge I_CLK);
        cl <= 32'h3;
        cr <= 32'h64;
        ien <= 4'hF;
        pcount = 0;
        load(32'hA);
        go(0);
        idle();
        check("pulses", pcount, 32'hA);
        check("logical pos", lpos, 32'hA);
        check("real pos", rpos, 32'hA);
        check("direction", dir, 32'h0);
        check("logical compare", cge, 32'h1);
        check("real compare", rge, 32'h0);
        check("end flag", flags[1], 32'h1);
        check("compare flag", flags[2], 32'h1);
        check("interrupt", intr, 32'h1);
        @(posedge I_CLK);
        iclr <= 1'b1;
        @(posedge I_CLK);
        iclr <= 1'b0;
        cyc(2);
        check("flags cleared", {intr, flags}, 32'h0);
    endtask

    task automatic t_minus();
        pcount = 0;
        load(32'h5);
        go(1);
        upto(2);
        go(0);
        idle();
        check("minus pulses", pcount, 32'h5);
        check("minus dir", dir, 32'h1);
        check("minus pos", lpos, 32'h5);
    endtask

    task automatic t_change();
        int n;
        pcount = 0;
        load(32'h14);
        go(0);
        upto(5);
        load(32'h1E);
        idle();
        check("extended pulses", pcount, 32'h1E);
        pcount = 0;
        load(32'h14);
        go(0);
        upto(8);
        load(32'h3);
        n = pcount;
        cyc(4);
        check("cut short", drv, 32'h0);
        check("no extra pulse", pcount <= n + 1, 32'h1);
    endtask

    // 4 accel pulses, 40 total: decel starts after 40-4-offset pulses
    task automatic t_offset();
        int k;
        @(posedge I_CLK);
        dm <= 3'h2;
        dv <= 16'h1004;
        for (k = 0; k < 3; k++) begin
            @(posedge I_CLK);
            ofs <= (k == 0) ? 16'shFFF8 : 16'sh0000;
            if (k == 1) begin
                I_RESET <= 1'b1;
                cyc(2);
                @(posedge I_CLK);
                I_RESET <= 1'b0;
            end else begin
                go(7);
            end
            sawdec = 1'b0;
            sawacc = 1'b0;
            dec_at = 0;
            pcount = 0;
            load(32'h28);
            go(0);
            idle();
            check("offset pulses", pcount, 32'h28);
            check("accel seen", sawacc, 32'h1);
            check("decel start", dec_at, (k == 0) ? 32'h0 : ((k == 1) ? 32'h1C : 32'h24));
        end
        @(posedge I_CLK);
        dm <= 3'h0;
        dv <= 16'h1000;
        cl <= 32'h5A;
        lim <= 1'b1;
        load(32'h64);
        go(0);
        idle();
        check("limit pos", lpos, 32'h5A);
        check("limit flag", lhit, 32'h1);
        @(posedge I_CLK);
        lim <= 1'b0;
    endtask

    task automatic t_manual();
        @(posedge I_CLK);
        dm <= 3'h3;
        dv <= 16'h1008;
        dpt <= 32'h3;
        sawdec = 1'b0;
        pcount = 0;
        go(6);
        load(32'h14);
        go(0);
        idle();
        check("manual decel seen", sawdec, 32'h1);
        check("manual pulses", pcount, 32'h14);
    endtask

    task automatic t_cont();
        int k;
        int n;
        for (k = 4; k < 6; k++) begin
            @(posedge I_CLK);
            dm <= (k == 4) ? 3'h2 : 3'h0;
            dv <= (k == 4) ? 16'h1008 : 16'h1000;
            sawdec = 1'b0;
            pcount = 0;
            go(2);
            upto(12);
            if (k == 5) begin
                @(posedge I_CLK);
                dv <= 16'h1800;
                cyc(40);
                check("speed change", spd, 32'h1800);
            end
            go(k);
            n = pcount;
            cyc(4);
            if (k == 5) begin
                check("sudden stop", drv, 32'h0);
                check("sudden extra", pcount <= n + 1, 32'h1);
            end else begin
                idle();
                check("decel ramp", sawdec, 32'h1);
            end
        end
    endtask

    task automatic t_halt();
        int n;
        @(posedge I_CLK);
        dm <= 3'h0;
        dv <= 16'h1000;
        for (n = 0; n < 3; n++) begin
            @(posedge I_CLK);
            sm <= 6'h3 << (2 * n);
            fen <= 10'h001 << n;
            fsel <= 3'(n);
            pcount = 0;
            go(2);
            upto(3);
            @(posedge I_CLK);
            halt[n] <= 1'b1;
            cyc(16);
            check("halt stop", drv, 32'h0);
            @(posedge I_CLK);
            halt <= 3'h0;
        end
        @(posedge I_CLK);
        sm <= 6'h00;
        go(3);
        upto(2);
        @(posedge I_CLK);
        halt <= 3'h7;
        cyc(20);
        check("halt disabled", drv, 32'h1);
        go(5);
        idle();
        @(posedge I_CLK);
        sm <= 6'h01;
        dm <= 3'h2;
        dv <= 16'h1008;
        sawdec = 1'b0;
        pcount = 0;
        go(2);
        upto(12);
        @(posedge I_CLK);
        halt <= 3'h6;
        idle();
        check("halt decel", sawdec, 32'h1);
    endtask

    task automatic t_ext();
        @(posedge I_CLK);
        dm <= 3'h0;
        sm <= 6'h00;
        halt <= 3'h0;
        ext <= 3'h5;
        pcount = 0;
        upto(3);
        check("ext drive", drv, 32'h1);
        @(posedge I_CLK);
        ext <= 3'h0;
        idle();
        check("ext dir", dir, 32'h0);
    endtask

    initial begin
        repeat (10) @(posedge I_CLK);
        I_RESET <= 1'b0;
        cyc(1);
        check("reset pos", lpos, 32'h0);
        check("reset flags", {drv, flags}, 32'h0);
        t_fixed();
        t_minus();
        t_change();
        t_offset();
        t_manual();
        t_cont();
        t_halt();
        t_ext();
        print_verdict();
    end
    // the whole sequence needs well under 20k cycles
    initial begin
        repeat (60000) @(posedge I_CLK);
        errors++;
        print_verdict();
    end
endmodule
